//--- fmsr_cap_if.sv
// Interface between fault logic and the captured status holder
`timescale 1ns/1ps
interface fmsr_cap_if;
    logic                         capture;
    logic                         clear;
    logic [fmsr_pkg::DATA_W-1:0]  snapshot;
    logic [fmsr_pkg::DATA_W-1:0]  captured;

    modport ctl (
        output capture,
        output clear,
        output snapshot,
        input  captured
    );
    modport cap (
        input  capture,
        input  clear,
        input  snapshot,
        output captured
    );
endinterface

//--- fmsr_capture.sv
// Captured fault status holder
`timescale 1ns/1ps
module fmsr_capture (
    input  wire logic clock,
    input  wire logic rst_n,
    fmsr_cap_if.cap   cap_io
);
    typedef struct packed {
        logic [fmsr_pkg::DATA_W-1:0] captured;
    } fmsr_cap_state_t;

    fmsr_cap_state_t st_ff;
    fmsr_cap_state_t nxt_st;

    // ************************************************************
    // Capture and clear
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        // capture on event
        // Capture beats a clear in the same cycle so no event is lost
        if (cap_io.capture) begin
            nxt_st.captured = cap_io.snapshot;
        end else if (cap_io.clear) begin
            nxt_st.captured = fmsr_pkg::CAPTURED_INIT;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.captured <= fmsr_pkg::CAPTURED_INIT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cap_io.captured = st_ff.captured;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    cap_take_a: assert property (cap_io.capture |=>
        cap_io.captured == $past(cap_io.snapshot))
        else $error("snapshot not taken on capture");
    cap_hold_a: assert property (!cap_io.capture && !cap_io.clear |=>
        $stable(cap_io.captured))
        else $error("captured status changed without cause");
    cap_clear_a: assert property (cap_io.clear && !cap_io.capture |=>
        cap_io.captured == fmsr_pkg::CAPTURED_INIT)
        else $error("captured status not cleared");
endmodule

//--- fmsr_host_model.sv
// Host model that reaches the fault registers through the strobe port
`timescale 1ns/1ps
module fmsr_host_model (
    input  wire logic                        clock,
    input  wire logic [fmsr_pkg::DATA_W-1:0] reg_rd_data,
    input  wire logic                        reg_rd_valid,
    output logic                             reg_wr_en,
    output logic                             reg_rd_en,
    output logic      [fmsr_pkg::ADDR_W-1:0] reg_addr,
    output logic      [fmsr_pkg::DATA_W-1:0] reg_wr_data
);
    initial begin
        reg_wr_en   = 1'b0;
        reg_rd_en   = 1'b0;
        reg_addr    = 8'h00;
        reg_wr_data = 8'h00;
    end

    // ************************************************************
    // Bus cycles
    // ************************************************************
    // Idle bus shows inverted values so stale data never looks valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_wr_en   = 1'b1;
        reg_addr    = a;
        reg_wr_data = d;
        @(posedge clock);
        #1;
        reg_wr_en   = 1'b0;
        reg_addr    = ~a;
        reg_wr_data = ~d;
    endtask

    // Write then read the same address in the very next cycle
    task automatic write_read(input logic [7:0] a, input logic [7:0] d,
                              output logic [7:0] q);
        @(posedge clock);
        #1;
        reg_wr_en   = 1'b1;
        reg_addr    = a;
        reg_wr_data = d;
        @(posedge clock);
        #1;
        reg_wr_en   = 1'b0;
        reg_rd_en   = 1'b1;
        reg_wr_data = ~d;
        @(posedge clock);
        #1;
        reg_rd_en   = 1'b0;
        reg_addr    = ~a;
        q = (reg_rd_valid === 1'b1) ? reg_rd_data : 8'hXX;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clock);
        #1;
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(posedge clock);
        #1;
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
        n = 0;
        while (reg_rd_valid !== 1'b1 && n < 4) begin
            @(posedge clock);
            #1;
            n++;
        end
        d = (reg_rd_valid === 1'b1) ? reg_rd_data : 8'hXX;
    endtask
endmodule

//--- fmsr_pkg.sv
// Package of constants for the fault mask and status register block
package fmsr_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned NUM_PG = 7;
    localparam int unsigned LIVE_W = 6;

    // ************************************************************
    // Sub-addresses
    // ************************************************************
    localparam logic [ADDR_W-1:0] ADDR_RST_MASK = 8'h0A;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0B;
    localparam logic [ADDR_W-1:0] ADDR_LIVE     = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_CAPTURED = 8'h0D;

    // ************************************************************
    // Reset values and fields
    // ************************************************************
    localparam logic [DATA_W-1:0] RST_MASK_INIT = 8'hFF;
    localparam logic [DATA_W-1:0] IRQ_MASK_INIT = 8'h00;
    localparam logic [DATA_W-1:0] CAPTURED_INIT = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO     = 8'h00;
    localparam logic [1:0]        LIVE_PAD      = 2'h0;
    localparam int unsigned       PG7_BIT       = 6;
endpackage

//--- fmsr_top.sv
// Fault mask and status registers, top level
`timescale 1ns/1ps
module fmsr_top (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic [fmsr_pkg::NUM_PG-1:0] power_good,
    input  wire logic                        undervoltage_flag,
    input  wire logic                        overtemp_flag,
    input  wire logic                        led_boost_mode,
    input  wire logic                        clear_interrupt_cmd,
    input  wire logic                        reg_wr_en,
    input  wire logic                        reg_rd_en,
    input  wire logic [fmsr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [fmsr_pkg::DATA_W-1:0] reg_wr_data,
    output logic      [fmsr_pkg::DATA_W-1:0] reg_rd_data,
    output logic                             reg_rd_valid,
    output logic                             reset_fault_out_n,
    output logic                             interrupt_out_n
);
    typedef struct packed {
        logic [fmsr_pkg::NUM_PG-1:0] pg_meta;
        logic [fmsr_pkg::NUM_PG-1:0] pg_sync;
        logic                        uv_meta;
        logic                        uv_sync;
        logic                        ot_meta;
        logic                        ot_sync;
        logic [fmsr_pkg::DATA_W-1:0] rst_mask;
        logic [fmsr_pkg::DATA_W-1:0] irq_mask;
        logic                        irq_cond;
        logic                        pending;
        logic                        rst_out_n;
        logic                        irq_out_n;
        logic [fmsr_pkg::DATA_W-1:0] rd_data;
        logic                        rd_valid;
    } fmsr_state_t;

    fmsr_state_t st_ff;
    fmsr_state_t nxt_st;

    fmsr_cap_if cap_bus ();

    logic [fmsr_pkg::NUM_PG-1:0] fault;
    logic                        rst_hit;
    logic                        irq_now;
    logic                        irq_event;

    function automatic logic addr_is(input logic [fmsr_pkg::ADDR_W-1:0] a,
                                     input logic [fmsr_pkg::ADDR_W-1:0] want);
        addr_is = (a == want);
    endfunction

    fmsr_capture u_capture (
        .clock  (clock),
        .rst_n  (rst_n),
        .cap_io (cap_bus.cap)
    );

    // ************************************************************
    // Fault routing
    // ************************************************************
    always_comb begin
        // power good low means output below threshold
        fault = ~st_ff.pg_sync;
        // regulator 7 ignored unless boost mode
        fault[fmsr_pkg::PG7_BIT] = fault[fmsr_pkg::PG7_BIT] & led_boost_mode;
        rst_hit = |(fault & st_ff.rst_mask[fmsr_pkg::NUM_PG-1:0]);
        // masked faults pull interrupt low
        // Warning flags always interrupt; they have no mask here
        irq_now = (|(fault & st_ff.irq_mask[fmsr_pkg::NUM_PG-1:0]))
                  | st_ff.uv_sync | st_ff.ot_sync;
        irq_event = irq_now & ~st_ff.irq_cond;
    end

    // snapshot taken on the rising interrupt condition
    assign cap_bus.capture  = irq_event;
    assign cap_bus.clear    = clear_interrupt_cmd;
    // captured layout: flags above power good 6..1
    assign cap_bus.snapshot = {st_ff.uv_sync, st_ff.ot_sync,
                               st_ff.pg_sync[fmsr_pkg::LIVE_W-1:0]};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        // Power good and flag pins are asynchronous, so two flops before any use
        nxt_st.pg_meta  = power_good;
        nxt_st.pg_sync  = st_ff.pg_meta;
        nxt_st.uv_meta  = undervoltage_flag;
        nxt_st.uv_sync  = st_ff.uv_meta;
        nxt_st.ot_meta  = overtemp_flag;
        nxt_st.ot_sync  = st_ff.ot_meta;
        nxt_st.irq_cond = irq_now;
        // pending holds interrupt low until cleared; set wins
        if (irq_event) begin
            nxt_st.pending = 1'b1;
        end else if (clear_interrupt_cmd) begin
            nxt_st.pending = 1'b0;
        end
        nxt_st.rst_out_n = ~rst_hit;
        nxt_st.irq_out_n = ~(irq_now | st_ff.pending);

        if (reg_wr_en && addr_is(reg_addr, fmsr_pkg::ADDR_RST_MASK)) begin
            nxt_st.rst_mask = reg_wr_data;
        end
        if (reg_wr_en && addr_is(reg_addr, fmsr_pkg::ADDR_IRQ_MASK)) begin
            nxt_st.irq_mask = reg_wr_data;
        end
        // status addresses have no write path

        nxt_st.rd_valid = reg_rd_en;
        if (reg_rd_en) begin
            if (addr_is(reg_addr, fmsr_pkg::ADDR_RST_MASK)) begin
                nxt_st.rd_data = st_ff.rst_mask;
            end else if (addr_is(reg_addr, fmsr_pkg::ADDR_IRQ_MASK)) begin
                nxt_st.rd_data = st_ff.irq_mask;
            end else if (addr_is(reg_addr, fmsr_pkg::ADDR_LIVE)) begin
                nxt_st.rd_data = {fmsr_pkg::LIVE_PAD,
                                  st_ff.pg_sync[fmsr_pkg::LIVE_W-1:0]};
            end else if (addr_is(reg_addr, fmsr_pkg::ADDR_CAPTURED)) begin
                nxt_st.rd_data = cap_bus.captured;
            end else begin
                nxt_st.rd_data = fmsr_pkg::READ_ZERO;
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Synchronisers start at good so reset shows no fault
            st_ff.pg_meta   <= '1;
            st_ff.pg_sync   <= '1;
            st_ff.uv_meta   <= 1'b0;
            st_ff.uv_sync   <= 1'b0;
            st_ff.ot_meta   <= 1'b0;
            st_ff.ot_sync   <= 1'b0;
            // reset mask defaults to all ones
            st_ff.rst_mask  <= fmsr_pkg::RST_MASK_INIT;
            st_ff.irq_mask  <= fmsr_pkg::IRQ_MASK_INIT;
            st_ff.irq_cond  <= 1'b0;
            st_ff.pending   <= 1'b0;
            st_ff.rst_out_n <= 1'b1;
            st_ff.irq_out_n <= 1'b1;
            st_ff.rd_data   <= fmsr_pkg::READ_ZERO;
            st_ff.rd_valid  <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rd_data       = st_ff.rd_data;
    assign reg_rd_valid      = st_ff.rd_valid;
    assign reset_fault_out_n = st_ff.rst_out_n;
    assign interrupt_out_n   = st_ff.irq_out_n;

    // ************************************************************
    // Checks
    // ************************************************************
    // Helper: reset mask never written since reset
    logic rmask_fresh_ff;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rmask_fresh_ff <= 1'b1;
        end else if (reg_wr_en && addr_is(reg_addr, fmsr_pkg::ADDR_RST_MASK)) begin
            rmask_fresh_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence irq_rise_s;
        irq_event;
    endsequence
    sequence irq_held_s;
        !interrupt_out_n [*2];
    endsequence

    rst_drive_a: assert property (rst_hit |=> !reset_fault_out_n)
        else $error("reset output not low on masked fault");
    rst_release_a: assert property (!rst_hit |=> reset_fault_out_n)
        else $error("reset output low without masked fault");
    rst_default_a: assert property (rmask_fresh_ff && reg_rd_en
        && addr_is(reg_addr, fmsr_pkg::ADDR_RST_MASK)
        |=> reg_rd_data == fmsr_pkg::RST_MASK_INIT)
        else $error("reset mask default wrong");
    mask_write_a: assert property (reg_wr_en
        && addr_is(reg_addr, fmsr_pkg::ADDR_RST_MASK) ##1 reg_rd_en
        && addr_is(reg_addr, fmsr_pkg::ADDR_RST_MASK) && !reg_wr_en
        |=> reg_rd_data == $past(reg_wr_data, 2))
        else $error("reset mask readback wrong");
    irq_drive_a: assert property (irq_now |=> !interrupt_out_n)
        else $error("interrupt output not low on fault");
    irq_pend_a: assert property (irq_rise_s ##1 !clear_interrupt_cmd
        |-> irq_held_s)
        else $error("interrupt not held after event");
    boost_gate_a: assert property (!led_boost_mode && !st_ff.pending
        && st_ff.pg_sync[fmsr_pkg::LIVE_W-1:0] == '1 && !st_ff.uv_sync
        && !st_ff.ot_sync |=> reset_fault_out_n && interrupt_out_n)
        else $error("regulator 7 fault acted outside boost mode");
    live_read_a: assert property (reg_rd_en
        && addr_is(reg_addr, fmsr_pkg::ADDR_LIVE) |=> reg_rd_valid
        && reg_rd_data == {fmsr_pkg::LIVE_PAD,
                           $past(st_ff.pg_sync[fmsr_pkg::LIVE_W-1:0])})
        else $error("live status read wrong");
    ro_write_a: assert property (reg_wr_en && !irq_event
        && !clear_interrupt_cmd
        && (addr_is(reg_addr, fmsr_pkg::ADDR_LIVE)
            || addr_is(reg_addr, fmsr_pkg::ADDR_CAPTURED))
        |=> $stable(cap_bus.captured) && $stable(st_ff.rst_mask)
            && $stable(st_ff.irq_mask))
        else $error("status write changed state");
endmodule

//--- testbench.sv
// Self-checking bench for the fault mask and status registers
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    comparisons++; \
    if ((got) !== (exp)) begin \
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
        error_cnt++; \
    end
module testbench;
    logic       clock;
    logic       rst_n;
    logic [6:0] power_good;
    logic       undervoltage_flag;
    logic       overtemp_flag;
    logic       led_boost_mode;
    logic       clear_interrupt_cmd;
    logic       reg_wr_en;
    logic       reg_rd_en;
    logic [7:0] reg_addr;
    logic [7:0] reg_wr_data;
    logic [7:0] reg_rd_data;
    logic       reg_rd_valid;
    logic       reset_fault_out_n;
    logic       interrupt_out_n;
    logic [7:0] rd_byte;
    int         error_cnt   = 0;
    int         comparisons = 0;
    int         cycle_cnt   = 0;

    fmsr_top uut (.clock(clock), .rst_n(rst_n), .power_good(power_good),
        .undervoltage_flag(undervoltage_flag), .overtemp_flag(overtemp_flag),
        .led_boost_mode(led_boost_mode), .clear_interrupt_cmd(clear_interrupt_cmd),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .reset_fault_out_n(reset_fault_out_n),
        .interrupt_out_n(interrupt_out_n));

    fmsr_host_model host (.clock(clock), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        `CHK($sformatf("register %h", a), exp, d)
    endtask

    task automatic chk_out(input logic rst_exp, input logic irq_exp);
        `CHK("reset_fault_out_n", rst_exp, reset_fault_out_n)
        `CHK("interrupt_out_n", irq_exp, interrupt_out_n)
    endtask

    // Pins are asynchronous: allow the two sync stages and the output flop
    task automatic set_pins(input logic [6:0] pg, input logic uv, input logic ot);
        @(posedge clock);
        #1;
        power_good        = pg;
        undervoltage_flag = uv;
        overtemp_flag     = ot;
        repeat (5) @(posedge clock);
        #1;
    endtask

    task automatic pulse_clear();
        @(posedge clock);
        #1;
        clear_interrupt_cmd = 1'b1;
        @(posedge clock);
        #1;
        clear_interrupt_cmd = 1'b0;
        @(posedge clock);
        #1;
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        cycle_cnt++;
        if (cycle_cnt == 2000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst_n               = 1'b0;
        power_good          = 7'h7F;
        undervoltage_flag   = 1'b0;
        overtemp_flag       = 1'b0;
        led_boost_mode      = 1'b0;
        clear_interrupt_cmd = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chk_rd(fmsr_pkg::ADDR_RST_MASK, 8'hFF);
        chk_rd(fmsr_pkg::ADDR_IRQ_MASK, 8'h00);
        chk_rd(fmsr_pkg::ADDR_LIVE, 8'h3F);
        chk_rd(fmsr_pkg::ADDR_CAPTURED, 8'h00);
        chk_rd(8'h10, 8'h00);
        chk_out(1'b1, 1'b1);
        host.write_reg(fmsr_pkg::ADDR_RST_MASK, 8'hA5);
        chk_rd(fmsr_pkg::ADDR_RST_MASK, 8'hA5);
        host.write_read(fmsr_pkg::ADDR_RST_MASK, 8'h5A, rd_byte);
        `CHK("reset mask write then read", 8'h5A, rd_byte)
        host.write_reg(fmsr_pkg::ADDR_RST_MASK, 8'hFF);
        set_pins(7'h7E, 1'b0, 1'b0);
        chk_out(1'b0, 1'b1);
        chk_rd(fmsr_pkg::ADDR_LIVE, 8'h3E);
        host.write_reg(fmsr_pkg::ADDR_RST_MASK, 8'h7E);
        @(posedge clock);
        #1;
        chk_out(1'b1, 1'b1);
        host.write_reg(fmsr_pkg::ADDR_RST_MASK, 8'hFF);
        set_pins(7'h3F, 1'b0, 1'b0);
        chk_out(1'b1, 1'b1);
        led_boost_mode = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk_out(1'b0, 1'b1);
        set_pins(7'h7F, 1'b0, 1'b0);
        led_boost_mode = 1'b0;
        host.write_reg(fmsr_pkg::ADDR_RST_MASK, 8'h00);
        host.write_reg(fmsr_pkg::ADDR_IRQ_MASK, 8'h02);
        chk_rd(fmsr_pkg::ADDR_IRQ_MASK, 8'h02);
        set_pins(7'h7D, 1'b0, 1'b0);
        chk_out(1'b1, 1'b0);
        chk_rd(fmsr_pkg::ADDR_CAPTURED, 8'h3D);
        set_pins(7'h7F, 1'b0, 1'b0);
        chk_rd(fmsr_pkg::ADDR_CAPTURED, 8'h3D);
        chk_out(1'b1, 1'b0);
        pulse_clear();
        chk_rd(fmsr_pkg::ADDR_CAPTURED, 8'h00);
        chk_out(1'b1, 1'b1);
        set_pins(7'h7F, 1'b1, 1'b1);
        chk_out(1'b1, 1'b0);
        chk_rd(fmsr_pkg::ADDR_CAPTURED, 8'hFF);
        host.write_reg(fmsr_pkg::ADDR_CAPTURED, 8'h00);
        chk_rd(fmsr_pkg::ADDR_CAPTURED, 8'hFF);
        host.write_reg(fmsr_pkg::ADDR_LIVE, 8'h00);
        chk_rd(fmsr_pkg::ADDR_LIVE, 8'h3F);
        set_pins(7'h7F, 1'b0, 1'b0);
        pulse_clear();
        chk_rd(fmsr_pkg::ADDR_CAPTURED, 8'h00);
        // Second reset must bring the masks back to defaults
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chk_rd(fmsr_pkg::ADDR_RST_MASK, 8'hFF);
        chk_rd(fmsr_pkg::ADDR_IRQ_MASK, 8'h00);
        print_verdict();
    end
endmodule
